// ### sib_regs.vh
`ifndef SIB_REGS_VH
`define SIB_REGS_VH
// ****************************************
// bus address and timing
// ****************************************
`define SIB_ADDR          7'h40
`define SIB_CLK_MHZ       200
`define SIB_PWRUP_MS      15
`define SIB_PWRUP_CYC     (`SIB_PWRUP_MS * 1000 * `SIB_CLK_MHZ)
`define SIB_VD_NS         400
`define SIB_VD_CYC        ((`SIB_VD_NS * `SIB_CLK_MHZ) / 1000)
`define SIB_OUT_DLY       0
`define SIB_BIT_START     4'hf
`define SIB_BIT_ACK       4'h8
`define SIB_BIT_LAST      4'h7
`endif

// ### sib_sync.v
`timescale 1ns/10ps
module sib_sync
(
   input  wire clk_in,
   input  wire nrst_in,
   input  wire pin_in,
   output reg  level_out
);
   reg [2:0] stage;
   always @(posedge clk_in or negedge nrst_in)
   begin
      if (!nrst_in)
      begin
         stage     <= 3'h7;
         level_out <= 1'b1;
      end
      else
      begin
         stage <= {stage[1:0], pin_in};
         // change only once second and third stages agree
         if (stage[1] == stage[2])
            level_out <= stage[2];
      end
   end
endmodule // sib_sync

// ### sib_target.v
// Function
// - static logic, no minimum clock rate
// - drive data shortly after clock falls
// - only pull lines low or release
// - ready within power-up wait time
// - one fixed target address only
// - match address, acknowledge in ninth clock
// - hold clock low while measuring
`timescale 1ns/10ps
`include "sib_regs.vh"
module sib_target
#(
   parameter PWRUP_CYC = `SIB_PWRUP_CYC
)
(
   input  wire       clk_in,
   input  wire       nrst_in,
   input  wire       scl_in,
   input  wire       sda_in,
   output reg        scl_out,
   output reg        scl_oe_out,
   output reg        sda_out,
   output reg        sda_oe_out,
   output reg        ready_out,
   output reg        rx_valid_out,
   output reg  [7:0] rx_data_out,
   output reg        rx_first_out,
   input  wire [7:0] tx_data_in,
   output reg        tx_take_out,
   input  wire       hold_req_in,
   output reg        busy_out
);
   // ****************************************
   // state encoding
   // ****************************************
   localparam ST_IDLE = 4'h1;
   localparam ST_ADDR = 4'h2;
   localparam ST_WR   = 4'h4;
   localparam ST_RD   = 4'h8;

   wire       scl_s;
   wire       sda_s;
   reg        scl_d;
   reg        sda_d;
   reg [3:0]  state;
   reg [3:0]  bitn;
   reg [7:0]  shreg;
   reg [7:0]  txreg;
   reg        ack_pend;
   reg        rd_nack;
   reg [31:0] pwr_cnt;
   reg [7:0]  dly_cnt;
   reg        dly_act;
   reg        next_sda;

   sib_sync u_scl
   (
      .clk_in    (clk_in),
      .nrst_in   (nrst_in),
      .pin_in    (scl_in),
      .level_out (scl_s)
   );
   sib_sync u_sda
   (
      .clk_in    (clk_in),
      .nrst_in   (nrst_in),
      .pin_in    (sda_in),
      .level_out (sda_s)
   );

   // edges sampled purely from levels; any slow or paused scl works
   wire scl_rise = scl_s & ~scl_d;
   wire scl_fall = ~scl_s & scl_d;
   wire start_c  = scl_s & scl_d & sda_d & ~sda_s;
   wire stop_c   = scl_s & scl_d & ~sda_d & sda_s;

   // ****************************************
   // power-up wait
   // ****************************************
   always @(posedge clk_in or negedge nrst_in)
   begin
      if (!nrst_in)
      begin
         pwr_cnt   <= 32'h0;
         ready_out <= 1'b0;
      end
      else if (!ready_out)
      begin
         pwr_cnt <= pwr_cnt + 32'h1;
         if (pwr_cnt >= PWRUP_CYC - 1)
            ready_out <= 1'b1;
      end
   end

   // ****************************************
   // protocol engine
   // ****************************************
   always @(posedge clk_in or negedge nrst_in)
   begin
      if (!nrst_in)
      begin
         scl_d        <= 1'b1;
         sda_d        <= 1'b1;
         state        <= ST_IDLE;
         bitn         <= 4'h0;
         shreg        <= 8'h00;
         txreg        <= 8'hff;
         ack_pend     <= 1'b0;
         rd_nack      <= 1'b0;
         rx_valid_out <= 1'b0;
         rx_data_out  <= 8'h00;
         rx_first_out <= 1'b0;
         tx_take_out  <= 1'b0;
         dly_cnt      <= 8'h00;
         dly_act      <= 1'b0;
         next_sda     <= 1'b1;
      end
      else
      begin
         scl_d        <= scl_s;
         sda_d        <= sda_s;
         rx_valid_out <= 1'b0;
         tx_take_out  <= 1'b0;
         if (dly_act)
         begin
            dly_cnt <= dly_cnt + 8'h1;
            if (dly_cnt == `SIB_OUT_DLY)
               dly_act <= 1'b0;
         end
         if (!ready_out)
            state <= ST_IDLE;
         else if (stop_c)
            state <= ST_IDLE;
         else if (start_c)
         begin
            state    <= ST_ADDR;
            // the start's own scl fall wraps this to bit 0
            bitn     <= `SIB_BIT_START;
            ack_pend <= 1'b0;
            next_sda <= 1'b1;
         end
         else if (scl_rise && state != ST_IDLE)
         begin
            // data taken on rise; master keeps it through high phase
            if (bitn <= `SIB_BIT_LAST)
               shreg <= {shreg[6:0], sda_s};
            else if (state == ST_RD)
               rd_nack <= sda_s;
         end
         else if (scl_fall && state != ST_IDLE)
         begin
            dly_act <= 1'b1;
            dly_cnt <= 8'h00;
            if (bitn == `SIB_BIT_LAST && state != ST_RD)
            begin
               bitn <= `SIB_BIT_ACK;
               if (state == ST_ADDR)
               begin
                  // single fixed address, no selection
                  if (shreg[7:1] == `SIB_ADDR)
                  begin
                     next_sda <= 1'b0;
                     ack_pend <= 1'b1;
                     state    <= shreg[0] ? ST_RD : ST_WR;
                     rx_first_out <= 1'b1;
                  end
                  else
                     state <= ST_IDLE;
               end
               else
               begin
                  next_sda     <= 1'b0;
                  rx_valid_out <= 1'b1;
                  rx_data_out  <= shreg;
               end
            end
            else if (bitn == `SIB_BIT_ACK)
            begin
               bitn     <= 4'h0;
               ack_pend <= 1'b0;
               rx_first_out <= 1'b0;
               if (state == ST_RD && ack_pend)
               begin
                  txreg       <= {tx_data_in[6:0], 1'b1};
                  next_sda    <= tx_data_in[7];
                  tx_take_out <= 1'b1;
               end
               else if (state == ST_RD && !rd_nack)
               begin
                  txreg       <= {tx_data_in[6:0], 1'b1};
                  next_sda    <= tx_data_in[7];
                  tx_take_out <= 1'b1;
               end
               else if (state == ST_RD)
               begin
                  next_sda <= 1'b1;
                  state    <= ST_IDLE;
               end
               else
                  next_sda <= 1'b1;
            end
            else if (state == ST_RD && bitn == `SIB_BIT_LAST)
            begin
               bitn     <= `SIB_BIT_ACK;
               next_sda <= 1'b1;
            end
            else
            begin
               bitn <= bitn + 4'h1;
               if (state == ST_RD)
               begin
                  next_sda <= txreg[7];
                  txreg    <= {txreg[6:0], 1'b1};
               end
            end
         end
      end
   end

   // ****************************************
   // open-drain pin drivers
   // ****************************************
   // output changes only after short delay past the falling edge,
   // well inside the valid-time window
   always @(posedge clk_in or negedge nrst_in)
   begin
      if (!nrst_in)
      begin
         sda_out    <= 1'b0;
         sda_oe_out <= 1'b0;
         scl_out    <= 1'b0;
         scl_oe_out <= 1'b0;
         busy_out   <= 1'b0;
      end
      else
      begin
         sda_out <= 1'b0;
         scl_out <= 1'b0;
         if (!ready_out || state == ST_IDLE)
            sda_oe_out <= 1'b0;
         else if (!dly_act && !scl_s)
            sda_oe_out <= ~next_sda;
         // clock stretch at any bit, while scl low and not idle
         busy_out   <= hold_req_in & ready_out;
         scl_oe_out <= ready_out & hold_req_in
                       & (scl_oe_out | ~scl_s)
                       & (state != ST_IDLE);
      end
   end
endmodule // sib_target

// ### sib_target_asserts.sv
`timescale 1ns/10ps
module sib_target_asserts
#(
   parameter PWRUP_CYC = 200
)
(
   input wire       clk_in,
   input wire       nrst_in,
   input wire       scl_in,
   input wire       sda_in,
   input wire       scl_out,
   input wire       scl_oe_out,
   input wire       sda_out,
   input wire       sda_oe_out,
   input wire       ready_out,
   input wire       rx_valid_out,
   input wire [7:0] rx_data_out,
   input wire       rx_first_out,
   input wire [7:0] tx_data_in,
   input wire       tx_take_out,
   input wire       hold_req_in,
   input wire       busy_out
);
   // ****************
   // power-up counter
   // ****************
   integer up_cnt;
   always @(posedge clk_in or negedge nrst_in)
      if (!nrst_in)
         up_cnt <= 0;
      else if (!ready_out)
         up_cnt <= up_cnt + 1;
   default clocking @(posedge clk_in);
   endclocking
   default disable iff (!nrst_in);
   a_pull_only_low: assert property (!sda_out && !scl_out)
      else $error("bus line driven high");
   a_quiet_before_up: assert property (!ready_out |-> !sda_oe_out && !scl_oe_out)
      else $error("bus driven before ready");
   a_ready_delay: assert property ($rose(ready_out) |->
      up_cnt >= PWRUP_CYC - 2 && up_cnt <= PWRUP_CYC + 1)
      else $error("ready at wrong time");
   a_ack_on_match: assert property ($rose(rx_first_out) |-> ##[1:4] sda_oe_out)
      else $error("address ack missing");
   a_stretch_held: assert property (scl_oe_out && hold_req_in |=> scl_oe_out)
      else $error("clock released while holding");
   a_stretch_ends: assert property (!hold_req_in [*4] |-> !scl_oe_out)
      else $error("clock held without request");
   a_busy_follows: assert property (hold_req_in && ready_out |=> busy_out)
      else $error("busy not set");
   a_tx_take_pulse: assert property (tx_take_out |=> !tx_take_out)
      else $error("take longer than a pulse");
endmodule // sib_target_asserts
bind sib_target sib_target_asserts #(.PWRUP_CYC(PWRUP_CYC)) u_chk
   (.clk_in(clk_in), .nrst_in(nrst_in), .scl_in(scl_in), .sda_in(sda_in),
    .scl_out(scl_out), .scl_oe_out(scl_oe_out), .sda_out(sda_out),
    .sda_oe_out(sda_oe_out), .ready_out(ready_out),
    .rx_valid_out(rx_valid_out), .rx_data_out(rx_data_out),
    .rx_first_out(rx_first_out), .tx_data_in(tx_data_in),
    .tx_take_out(tx_take_out), .hold_req_in(hold_req_in),
    .busy_out(busy_out));

// ### sib_master.sv
`timescale 1ns/10ps
module sib_master
(
   input  wire scl_in,
   input  wire sda_in,
   output reg  scl_oe_out,
   output reg  sda_oe_out
);
   // **********************************
   // bus master, lines only pulled low
   // **********************************
   localparam HALF = 24;
   // data bits: long low phase leaves room for the target's sync lag
   localparam LOW  = 38;
   localparam HIGH = 10;
   initial
   begin
      scl_oe_out = 1'b0; // idle clock high
      sda_oe_out = 1'b0;
   end
   task start();
      begin
         #6 sda_oe_out = 1'b0;
         #HALF scl_oe_out = 1'b0;
         #HALF sda_oe_out = 1'b1;
         #HALF scl_oe_out = 1'b1;
      end
   endtask
   task stop();
      begin
         #6 sda_oe_out = 1'b1;
         #HALF scl_oe_out = 1'b0;
         #HALF sda_oe_out = 1'b0;
      end
   endtask
   // data moves a little after the fall so no false start is seen
   task bit_io(input logic b, output logic r);
      integer i;
      begin
         #6 sda_oe_out = !b;
         #(LOW - 6) scl_oe_out = 1'b0;
         for (i = 0; i < 20000 && !scl_in; i = i + 1)
            #1;
         #HIGH r = sda_in;
         scl_oe_out = 1'b1;
      end
   endtask
   task xfer(input logic [7:0] d, input logic ak, output logic [7:0] q,
             output logic nak);
      integer k;
      begin
         for (k = 7; k >= 0; k = k - 1)
            bit_io(d[k], q[k]);
         bit_io(ak, nak);
      end
   endtask
endmodule // sib_master

// ### sib_target_tb.sv
`timescale 1ns/10ps
module sib_target_tb;
   logic        clk_in = 1'b0;
   logic        nrst_in = 1'b0;
   logic        hold = 1'b0;
   logic [7:0]  tx = 8'h00;
   logic [7:0]  rx, q;
   logic        scl_oe, sda_oe, m_scl, m_sda, scl, sda, busy, ready, n;
   logic        rxv;
   integer      rx_cnt = 0;
   logic [16:0] rows [4] = '{{8'h80, 1'b0, 8'h5a}, {8'h81, 1'b0, 8'ha5},
                             {8'h82, 1'b1, 8'h00}, {8'h01, 1'b1, 8'h00}};
   integer      err_count = 0;
   integer      total_checks = 0;
   integer      i;
   assign scl = !(scl_oe || m_scl);
   assign sda = !(sda_oe || m_sda);
   always #2.5 clk_in = ~clk_in;
   always @(posedge clk_in)
      if (rxv === 1'b1)
         rx_cnt <= rx_cnt + 1;
   sib_target #(.PWRUP_CYC(200)) dut
      (.clk_in(clk_in), .nrst_in(nrst_in), .scl_in(scl), .sda_in(sda),
       .scl_out(), .scl_oe_out(scl_oe), .sda_out(), .sda_oe_out(sda_oe),
       .ready_out(ready), .rx_valid_out(rxv), .rx_data_out(rx),
       .rx_first_out(), .tx_data_in(tx), .tx_take_out(),
       .hold_req_in(hold), .busy_out(busy));
   sib_master m (.scl_in(scl), .sda_in(sda), .scl_oe_out(m_scl),
                 .sda_oe_out(m_sda));
   task chk(input string nm, input logic [7:0] e, input logic [7:0] g);
      begin
         total_checks = total_checks + 1;
         if (g !== e)
         begin
            err_count = err_count + 1;
            $display("ERROR %s exp %h got %h", nm, e, g);
         end
      end
   endtask
   task summarize();
      begin
         if (err_count == 0 && total_checks > 0)
            $display("All checks passed");
         else
            $display("Checks failed");
         $finish;
      end
   endtask
   initial
   begin
      #100000;
      err_count = err_count + 1;
      summarize();
   end
   initial
   begin
      repeat (8) @(posedge clk_in);
      nrst_in <= 1'b1;
      @(posedge clk_in);
      chk("ready", 8'h00, ready);
      m.start();
      m.xfer(8'h80, 1'b1, q, n);
      m.stop();
      chk("early_ack", 8'h01, n);
      for (i = 0; i < 4000 && ready !== 1'b1; i = i + 1)
         @(posedge clk_in);
      chk("ready", 8'h01, ready);
      foreach (rows[k])
      begin
         @(posedge clk_in);
         tx <= rows[k][7:0];
         m.start();
         m.xfer(rows[k][16:9], 1'b1, q, n);
         chk("hdr_ack", rows[k][8], n);
         if (!n && rows[k][9])
         begin
            m.xfer(8'hff, 1'b1, q, n);
            chk("rd_data", rows[k][7:0], q);
         end
         else if (!n)
         begin
            m.xfer(rows[k][7:0], 1'b1, q, n);
            chk("wr_ack", 8'h00, n);
            chk("wr_data", rows[k][7:0], rx);
         end
         m.stop();
      end
      m.start();
      m.xfer(8'h80, 1'b1, q, n);
      @(posedge clk_in);
      hold <= 1'b1;
      fork
         begin
            repeat (8) @(posedge clk_in);
            m.xfer(8'he3, 1'b1, q, n);
         end
         begin
            repeat (300) @(posedge clk_in);
            chk("stretch", 8'h01, scl_oe);
            chk("busy", 8'h01, busy);
            hold <= 1'b0;
         end
      join
      chk("cmd_ack", 8'h00, n);
      chk("cmd", 8'he3, rx);
      m.stop();
      @(posedge clk_in);
      chk("rx_count", 8'h02, rx_cnt[7:0]);
      summarize();
   end
endmodule // sib_target_tb
